// *** core/tsg_consts.svh ***
// Operation
// - Status bits 15..7 show the frame position, 0 to 371, never above.
// - Frame position reads come from a coherent shadow copy; writes do nothing.
// - A handset times transmit and receive events from one frame counter.
// - A base station reports the transmit counter in the status position field.
// - Status bit 4 mirrors the role pin, 1 handset, 0 base; writes ignored.
// - Status bit 3 sets when the selected sync word is found; writes ignored.
// - Status bit 2 sets when a new frame begins; writes ignored.
// - Writing the new-frame clear bit from 1 to 0 clears that flag.
// - Writing the sync-found clear bit from 1 to 0 clears that flag.
// - Search-word select 0 hunts the marker word, 1 the alternate pattern; resets 0.
// - Port 0 direction bits set each pin, 0 input, 1 output; read/write.
// - Port 1 direction bits set each pin, 0 input, 1 output; read/write.
// - Port data reads return sampled pin levels whatever the direction.
// - Port data writes load the levels driven on output pins.
// - Mailbox reads return the codec status byte low, zero upper byte.
// - Mailbox writes pass the low byte to the codec as a command.
// - Receive control reads return the link quality estimate, refreshed each frame.
// - Receive control writes store the marker position; receive counter loads it on detect if it is 371 or less.
//
// Purpose: Offsets, field positions and reset values of the status/port bank.
// Assumes: Included by tsg_frame_counter and tsg_status_regs.
// Notes:   Definitions only.
`ifndef TSG_CONSTS_SVH
`define TSG_CONSTS_SVH

// ----------------------------------------------------------------
// Bank and register selects
// ----------------------------------------------------------------
`define TSG_BANK_RX 2'h2
`define TSG_BANK_FRAME 2'h3
`define TSG_EXT_MAILBOX 3'h0
`define TSG_EXT_RX_QUALITY 3'h1
`define TSG_EXT_FRAME_CTRL 3'h2
`define TSG_EXT_FRAME_STATUS 3'h3
`define TSG_EXT_PORT0_DIR 3'h4
`define TSG_EXT_PORT0_LEVELS 3'h5
`define TSG_EXT_PORT1_DIR 3'h6
`define TSG_EXT_PORT1_LEVELS 3'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TSG_STAT_POS_MSB 15
`define TSG_STAT_POS_LSB 7
`define TSG_STAT_ROLE_BIT 4
`define TSG_STAT_SYNC_BIT 3
`define TSG_STAT_FRAME_BIT 2
`define TSG_CTRL_SEARCH_BIT 9
`define TSG_CTRL_SYNC_CLR_BIT 5
`define TSG_CTRL_FRAME_CLR_BIT 4

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define TSG_FRAME_LAST 9'h173
`define TSG_POS_RESET 9'h000
`define TSG_WORD_RESET 16'h0000
`define TSG_BYTE_RESET 8'h00

`endif

// *** core/tsg_pkg.sv ***
// Purpose: Shared types of the status/port bank.
// Assumes: Nothing.
// Notes:   Constants live in tsg_consts.svh.
package tsg_pkg;
    typedef logic [8:0] tsg_pos_t;
    typedef logic [15:0] tsg_word_t;
    typedef logic [7:0] tsg_byte_t;
endpackage

// *** core/tsg_cnt_if.sv ***
// Purpose: Carries step, load and position between top and a frame counter.
// Assumes: One clock domain.
// Notes:   Counter owns pos and wrap.
`timescale 1ns/100ps
`default_nettype none
interface tsg_cnt_if;
    logic tick;
    logic load;
    tsg_pkg::tsg_pos_t load_val;
    tsg_pkg::tsg_pos_t pos;
    logic wrap;
    modport counter (input tick, input load, input load_val, output pos, output wrap);
    modport user (output tick, output load, output load_val, input pos, input wrap);
endinterface // tsg_cnt_if
`default_nettype wire

// *** core/tsg_frame_counter.sv ***
// Purpose: Bit-position counter of one frame, 0 to the last position.
// Assumes: tick is a one-cycle bit strobe on clk_sys_i.
// Notes:   A load outranks a tick; out-of-range loads are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "tsg_consts.svh"
module tsg_frame_counter (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Counter link
    tsg_cnt_if.counter cnt
);
    // ----------------------------------------------------------------
    // Position and wrap
    // ----------------------------------------------------------------
    // Illegal load values would break the range, so they are dropped
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt.pos <= `TSG_POS_RESET;
        end else if (cnt.load && (cnt.load_val <= `TSG_FRAME_LAST)) begin
            cnt.pos <= cnt.load_val;
        end else if (cnt.tick) begin
            cnt.pos <= (cnt.pos >= `TSG_FRAME_LAST) ? `TSG_POS_RESET : cnt.pos + 9'h001;
        end
    end

    // Wrap is high in the cycle that position 0 first shows; a dropped load must not hide it
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt.wrap <= 1'b0;
        end else begin
            cnt.wrap <= cnt.tick && !(cnt.load && (cnt.load_val <= `TSG_FRAME_LAST)) && (cnt.pos >= `TSG_FRAME_LAST);
        end
    end
endmodule // tsg_frame_counter
`default_nettype wire

// *** core/tsg_pin_sync.sv ***
// Purpose: Three-stage synchroniser for pin inputs.
// Assumes: Pins are asynchronous to clk_sys_i.
// Notes:   Output takes a bit once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module tsg_pin_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Pins and result
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] st2_r;
    logic [W-1:0] st3_r;

    // ----------------------------------------------------------------
    // Stages; meta_r feeds st2_r only, to contain metastability
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= '0;
            st2_r <= '0;
            st3_r <= '0;
        end else begin
            meta_r <= pin_i;
            st2_r <= meta_r;
            st3_r <= st2_r;
        end
    end

    // Accept a change per bit only when the last two stages match
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_o <= '0;
        end else begin
            level_o <= (st2_r & st3_r) | (level_o & (st2_r | st3_r));
        end
    end
endmodule // tsg_pin_sync
`default_nettype wire

// *** core/tsg_status_regs.sv ***
// Purpose: Frame status, two 16-bit ports, codec mailbox and receive control
//          registers reached over the banked external register port.
// Assumes: Bus strobes, bit tick and detector pulses are on clk_sys_i.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
`include "tsg_consts.svh"
module tsg_status_regs (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Banked register port
    input wire logic [1:0] bank_i,
    input wire logic [2:0] ext_addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    // Transceiver events
    input wire logic bit_tick_i,
    input wire logic marker_word_found_i,
    input wire logic alt_sync_found_i,
    input wire logic [15:0] link_quality_i,
    // Role pin
    input wire logic station_role_pin_i,
    // Port A pins
    input wire logic [15:0] port_a_in_i,
    output logic [15:0] port_a_out_o,
    output logic [15:0] port_a_oe_o,
    // Port B pins
    input wire logic [15:0] port_b_in_i,
    output logic [15:0] port_b_out_o,
    output logic [15:0] port_b_oe_o,
    // Voice codec mailbox
    input wire logic [7:0] voice_proc_state_byte_i,
    output logic [7:0] voice_proc_cmd_byte_o,
    output logic voice_proc_cmd_strobe_o,
    // Receiver and event timing
    output logic sync_search_word_o,
    output logic [8:0] marker_word_position_o,
    output logic [8:0] tx_event_pos_o,
    output logic [8:0] rx_event_pos_o
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    tsg_cnt_if rx_cnt ();
    tsg_cnt_if tx_cnt ();
    logic [15:0] port_a_levels;
    logic [15:0] port_b_levels;
    logic station_role_flag;
    logic rep_wrap;
    tsg_pkg::tsg_pos_t rep_pos;
    tsg_pkg::tsg_pos_t pos_shadow_r;
    logic new_frame_flag_r;
    logic sync_found_flag_r;
    logic new_frame_flag_clear_r;
    logic sync_found_flag_clear_r;
    logic sync_hit;
    logic wr_ctrl;
    logic new_frame_clr_pulse;
    logic sync_found_clr_pulse;
    logic [15:0] port_a_dir_bits_r;
    logic [15:0] port_b_dir_bits_r;
    logic [15:0] port_a_drive_r;
    logic [15:0] port_b_drive_r;
    tsg_pkg::tsg_word_t link_quality_estimate_r;
    logic [15:0] rdata_nxt;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    tsg_pin_sync #(.W(16)) u_sync_a (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .pin_i(port_a_in_i),
        .level_o(port_a_levels)
    );

    tsg_pin_sync #(.W(16)) u_sync_b (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .pin_i(port_b_in_i),
        .level_o(port_b_levels)
    );

    tsg_pin_sync #(.W(1)) u_sync_role (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .pin_i(station_role_pin_i),
        .level_o(station_role_flag)
    );

    // ----------------------------------------------------------------
    // Frame counters
    // ----------------------------------------------------------------
    // Receive counter is re-aligned on every marker word detection while the stored position is 371 or less
    assign rx_cnt.tick = bit_tick_i;
    assign rx_cnt.load = marker_word_found_i;
    assign rx_cnt.load_val = marker_word_position_o;
    assign tx_cnt.tick = bit_tick_i;
    assign tx_cnt.load = 1'b0;
    assign tx_cnt.load_val = `TSG_POS_RESET;

    tsg_frame_counter u_rx_cnt (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .cnt(rx_cnt)
    );

    tsg_frame_counter u_tx_cnt (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .cnt(tx_cnt)
    );

    // Handset runs on its single counter, base reports the transmit one
    assign rep_pos = station_role_flag ? rx_cnt.pos : tx_cnt.pos;
    assign rep_wrap = station_role_flag ? rx_cnt.wrap : tx_cnt.wrap;

    // Event positions for transmit and receive timing
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_event_pos_o <= `TSG_POS_RESET;
            rx_event_pos_o <= `TSG_POS_RESET;
        end else begin
            tx_event_pos_o <= rep_pos;
            rx_event_pos_o <= rx_cnt.pos;
        end
    end

    // Shadow is frozen during a read so the whole field is coherent
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pos_shadow_r <= `TSG_POS_RESET;
        end else if (!(rd_i && bank_i == `TSG_BANK_FRAME)) begin
            pos_shadow_r <= rep_pos;
        end
    end

    // ----------------------------------------------------------------
    // Frame control bits and sticky flags
    // ----------------------------------------------------------------
    assign wr_ctrl = wr_i && (bank_i == `TSG_BANK_FRAME) && (ext_addr_i == `TSG_EXT_FRAME_CTRL);
    assign new_frame_clr_pulse = wr_ctrl && new_frame_flag_clear_r && !wdata_i[`TSG_CTRL_FRAME_CLR_BIT];
    assign sync_found_clr_pulse = wr_ctrl && sync_found_flag_clear_r && !wdata_i[`TSG_CTRL_SYNC_CLR_BIT];
    assign sync_hit = sync_search_word_o ? alt_sync_found_i : marker_word_found_i;

    // Control bits hold the last value written
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_search_word_o <= 1'b0;
            new_frame_flag_clear_r <= 1'b0;
            sync_found_flag_clear_r <= 1'b0;
        end else if (wr_ctrl) begin
            sync_search_word_o <= wdata_i[`TSG_CTRL_SEARCH_BIT];
            new_frame_flag_clear_r <= wdata_i[`TSG_CTRL_FRAME_CLR_BIT];
            sync_found_flag_clear_r <= wdata_i[`TSG_CTRL_SYNC_CLR_BIT];
        end
    end

    // A frame start in the clearing cycle wins, so no frame is missed
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            new_frame_flag_r <= 1'b0;
        end else if (rep_wrap) begin
            new_frame_flag_r <= 1'b1;
        end else if (new_frame_clr_pulse) begin
            new_frame_flag_r <= 1'b0;
        end
    end

    // Sync detection likewise outranks its clear
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_found_flag_r <= 1'b0;
        end else if (sync_hit) begin
            sync_found_flag_r <= 1'b1;
        end else if (sync_found_clr_pulse) begin
            sync_found_flag_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // General-purpose ports
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_a_dir_bits_r <= `TSG_WORD_RESET;
            port_b_dir_bits_r <= `TSG_WORD_RESET;
        end else if (wr_i && bank_i == `TSG_BANK_FRAME) begin
            if (ext_addr_i == `TSG_EXT_PORT0_DIR) begin
                port_a_dir_bits_r <= wdata_i;
            end
            if (ext_addr_i == `TSG_EXT_PORT1_DIR) begin
                port_b_dir_bits_r <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_a_drive_r <= `TSG_WORD_RESET;
            port_b_drive_r <= `TSG_WORD_RESET;
        end else if (wr_i && bank_i == `TSG_BANK_FRAME) begin
            if (ext_addr_i == `TSG_EXT_PORT0_LEVELS) begin
                port_a_drive_r <= wdata_i;
            end
            if (ext_addr_i == `TSG_EXT_PORT1_LEVELS) begin
                port_b_drive_r <= wdata_i;
            end
        end
    end

    // Pin drivers; enable high where the pin is an output
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_a_out_o <= `TSG_WORD_RESET;
            port_a_oe_o <= `TSG_WORD_RESET;
            port_b_out_o <= `TSG_WORD_RESET;
            port_b_oe_o <= `TSG_WORD_RESET;
        end else begin
            port_a_out_o <= port_a_drive_r;
            port_a_oe_o <= port_a_dir_bits_r;
            port_b_out_o <= port_b_drive_r;
            port_b_oe_o <= port_b_dir_bits_r;
        end
    end

    // ----------------------------------------------------------------
    // Codec mailbox and receive control
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            voice_proc_cmd_byte_o <= `TSG_BYTE_RESET;
            voice_proc_cmd_strobe_o <= 1'b0;
        end else begin
            voice_proc_cmd_strobe_o <= wr_i && bank_i == `TSG_BANK_RX && ext_addr_i == `TSG_EXT_MAILBOX;
            if (wr_i && bank_i == `TSG_BANK_RX && ext_addr_i == `TSG_EXT_MAILBOX) begin
                voice_proc_cmd_byte_o <= wdata_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            marker_word_position_o <= `TSG_POS_RESET;
        end else if (wr_i && bank_i == `TSG_BANK_RX && ext_addr_i == `TSG_EXT_RX_QUALITY) begin
            marker_word_position_o <= wdata_i[8:0];
        end
    end

    // Sampled at frame start; software reads it in the next guard time
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link_quality_estimate_r <= `TSG_WORD_RESET;
        end else if (rep_wrap) begin
            link_quality_estimate_r <= link_quality_i;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = `TSG_WORD_RESET;
        if (bank_i == `TSG_BANK_FRAME) begin
            case (ext_addr_i)
                `TSG_EXT_FRAME_CTRL: begin
                    rdata_nxt[`TSG_CTRL_SEARCH_BIT] = sync_search_word_o;
                    rdata_nxt[`TSG_CTRL_SYNC_CLR_BIT] = sync_found_flag_clear_r;
                    rdata_nxt[`TSG_CTRL_FRAME_CLR_BIT] = new_frame_flag_clear_r;
                end
                `TSG_EXT_FRAME_STATUS: begin
                    rdata_nxt[`TSG_STAT_POS_MSB:`TSG_STAT_POS_LSB] = pos_shadow_r;
                    rdata_nxt[`TSG_STAT_ROLE_BIT] = station_role_flag;
                    rdata_nxt[`TSG_STAT_SYNC_BIT] = sync_found_flag_r;
                    rdata_nxt[`TSG_STAT_FRAME_BIT] = new_frame_flag_r;
                end
                `TSG_EXT_PORT0_DIR: rdata_nxt = port_a_dir_bits_r;
                `TSG_EXT_PORT0_LEVELS: rdata_nxt = port_a_levels;
                `TSG_EXT_PORT1_DIR: rdata_nxt = port_b_dir_bits_r;
                `TSG_EXT_PORT1_LEVELS: rdata_nxt = port_b_levels;
                default: rdata_nxt = `TSG_WORD_RESET;
            endcase
        end else if (bank_i == `TSG_BANK_RX) begin
            case (ext_addr_i)
                `TSG_EXT_MAILBOX: rdata_nxt = {8'h00, voice_proc_state_byte_i};
                `TSG_EXT_RX_QUALITY: rdata_nxt = link_quality_estimate_r;
                default: rdata_nxt = `TSG_WORD_RESET;
            endcase
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= `TSG_WORD_RESET;
        end else if (rd_i) begin
            rdata_o <= rdata_nxt;
        end
    end
endmodule // tsg_status_regs
`default_nettype wire

// *** verification/tsg_regs_monitor.sv ***
// Purpose: Port-level checks of the status/port register bank.
// Assumes: Bound to tsg_status_regs; one clock domain.
// Notes:   Read data lands one edge after the strobe.
`timescale 1ns/100ps
`default_nettype none
module tsg_regs_monitor (
    // Clock, reset and register port
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [1:0] bank_i,
    input wire logic [2:0] ext_addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] rdata_o,
    // Pins, mailbox and counters
    input wire logic station_role_pin_i,
    input wire logic [7:0] voice_proc_state_byte_i,
    input wire logic [15:0] port_a_out_o,
    input wire logic [15:0] port_a_oe_o,
    input wire logic [15:0] port_b_oe_o,
    input wire logic [7:0] voice_proc_cmd_byte_o,
    input wire logic voice_proc_cmd_strobe_o,
    input wire logic [8:0] tx_event_pos_o,
    input wire logic [8:0] rx_event_pos_o
);
    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    a_pos_legal: assert property (tx_event_pos_o <= 9'd371 && rx_event_pos_o <= 9'd371)
        else $error("frame position above last value");
    // Role pin passes the synchroniser in four edges; eight quiet cycles leave margin
    a_handset_one: assert property (station_role_pin_i [*8] |-> tx_event_pos_o == rx_event_pos_o)
        else $error("handset uses two counters");
    a_role_mirror: assert property (station_role_pin_i [*8] ##0 (rd_i && bank_i == 2'h3 && ext_addr_i == 3'h3)
        |=> rdata_o[4]) else $error("role bit not handset");
    a_stat_rsvd: assert property (rd_i && bank_i == 2'h3 && ext_addr_i == 3'h3 |=> (rdata_o & 16'h0063) == 16'h0000)
        else $error("status reserved bits set");
    a_dir_a: assert property (wr_i && bank_i == 2'h3 && ext_addr_i == 3'h4 |=> ##1 port_a_oe_o == $past(wdata_i, 2))
        else $error("port a enable wrong");
    a_dir_b: assert property (wr_i && bank_i == 2'h3 && ext_addr_i == 3'h6 |=> ##1 port_b_oe_o == $past(wdata_i, 2))
        else $error("port b enable wrong");
    a_drive_a: assert property (wr_i && bank_i == 2'h3 && ext_addr_i == 3'h5 |=> ##1 port_a_out_o == $past(wdata_i, 2))
        else $error("port a drive wrong");
    a_cmd_pass: assert property (wr_i && bank_i == 2'h2 && ext_addr_i == 3'h0 |=> voice_proc_cmd_strobe_o
        && {8'h00, voice_proc_cmd_byte_o} == ($past(wdata_i) & 16'h00ff)) else $error("command byte lost");
    a_mail_read: assert property (rd_i && bank_i == 2'h2 && ext_addr_i == 3'h0
        |=> rdata_o == {8'h00, $past(voice_proc_state_byte_i)}) else $error("mailbox read wrong");
    c_cmd: cover property (voice_proc_cmd_strobe_o);
    c_wrap: cover property (rx_event_pos_o == 9'd371 ##1 rx_event_pos_o == 9'd0);
    c_handset: cover property (station_role_pin_i [*8]);
endmodule // tsg_regs_monitor
`default_nettype wire

// *** verification/tsg_codec_model.sv ***
// Purpose: Voice codec on the far side of the mailbox.
// Assumes: Same clock as the bank.
// Notes:   Status echoes each command inverted in a known pattern.
`timescale 1ns/100ps
`default_nettype none
module tsg_codec_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Mailbox
    input wire logic [7:0] cmd_i,
    input wire logic strobe_i,
    output logic [7:0] state_o
);
    // Answer takes one edge, so a stale read would show
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_o <= 8'h00;
        end else if (strobe_i) begin
            state_o <= cmd_i ^ 8'h5a;
        end
    end
endmodule // tsg_codec_model
`default_nettype wire

// *** verification/tsg_status_regs_bench.sv ***
// Purpose: Self-checking bench of the status/port bank.
// Assumes: Inputs change on the falling edge.
// Notes:   Reads queue a masked expectation; a watcher compares.
`timescale 1ns/100ps
`default_nettype none
module tsg_status_regs_bench;
    // ------------------------------------------------
    // Stimulus and outputs
    // ------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [1:0] bank_i = 2'h0;
    logic [2:0] ext_addr_i = 3'h0;
    logic rd_i = 1'b0, wr_i = 1'b0, rd_d = 1'b0;
    logic bit_tick_i = 1'b0, marker_word_found_i = 1'b0, alt_sync_found_i = 1'b0, station_role_pin_i = 1'b0;
    logic [15:0] wdata_i = 16'h0000, link_quality_i = 16'h0000, ext_a = 16'h0000, ext_b = 16'h0000;
    logic [15:0] dir, lv, snr, ext;
    logic [31:0] note;
    logic [31:0] exp_q[$];
    int fails = 0, num_checks = 0;
    wire logic [15:0] rdata_o, port_a_out_o, port_a_oe_o, port_b_out_o, port_b_oe_o;
    wire logic [7:0] voice_proc_state_byte_i, voice_proc_cmd_byte_o;
    wire logic voice_proc_cmd_strobe_o, sync_search_word_o;
    wire logic [8:0] marker_word_position_o, tx_event_pos_o, rx_event_pos_o;
    // Pin level: our drive where enabled, the outside world elsewhere
    wire logic [15:0] port_a_in_i = (port_a_out_o & port_a_oe_o) | (ext_a & ~port_a_oe_o);
    wire logic [15:0] port_b_in_i = (port_b_out_o & port_b_oe_o) | (ext_b & ~port_b_oe_o);
    tsg_status_regs u_dut (.*);
    tsg_codec_model u_codec (.clk_sys_i, .rstn_i, .cmd_i(voice_proc_cmd_byte_o),
        .strobe_i(voice_proc_cmd_strobe_o), .state_o(voice_proc_state_byte_i));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic stop_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Extra idle cycle keeps two writes from touching wr_i in one step
    task automatic wr_reg(input logic [1:0] b, input logic [2:0] a, input logic [15:0] d);
        {bank_i, ext_addr_i, wdata_i, wr_i} = {b, a, d, 1'b1};
        @(negedge clk_sys_i);
        wr_i = 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic rd_reg(input logic [1:0] b, input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
        {bank_i, ext_addr_i, rd_i} = {b, a, 1'b1};
        exp_q.push_back({m, e & m});
        @(negedge clk_sys_i);
        rd_i = 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic step(input logic t, input logic m, input logic a, input int n);
        {bit_tick_i, marker_word_found_i, alt_sync_found_i} = {t, m, a};
        repeat (n) @(negedge clk_sys_i);
        {bit_tick_i, marker_word_found_i, alt_sync_found_i} = 3'b000;
        @(negedge clk_sys_i);
    endtask
    // Watcher: read data settles one edge after the strobe
    always @(posedge clk_sys_i) rd_d <= rd_i;
    always @(negedge clk_sys_i) begin
        if (rd_d) begin
            note = exp_q.pop_front();
            num_checks++;
            if ((rdata_o & note[31:16]) !== note[15:0]) begin
                fails++;
                $display("unexpected %0t: read %h want %h", $time, rdata_o, note[15:0]);
            end
        end
    end
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        fails++;
        $display("unexpected %0t: run hung", $time);
        stop_test();
    end
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        void'($urandom(32'ha446ae23));
        repeat (20) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        @(negedge clk_sys_i);
        // Base station: transmit counter shows, receive load does not
        step(1'b1, 1'b0, 1'b0, 100);
        wr_reg(2'h3, 3'h3, 16'hffff);
        rd_reg(2'h3, 3'h3, {9'd100, 7'h00}, 16'hffff);
        wr_reg(2'h2, 3'h1, 16'hfd2c);
        step(1'b0, 1'b1, 1'b0, 1);
        rd_reg(2'h3, 3'h3, {9'd100, 7'h08}, 16'hffff);
        // Handset: the loaded receive counter is the only one
        station_role_pin_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        rd_reg(2'h3, 3'h3, {9'd300, 7'h18}, 16'hffff);
        snr = 16'($urandom);
        link_quality_i = snr;
        step(1'b1, 1'b0, 1'b0, 72);
        link_quality_i = ~snr;
        rd_reg(2'h2, 3'h1, snr, 16'hffff);
        rd_reg(2'h3, 3'h3, 16'h001c, 16'hffff);
        // Each clear needs its control bit raised first
        wr_reg(2'h3, 3'h2, 16'h0030);
        rd_reg(2'h3, 3'h2, 16'h0030, 16'hffff);
        wr_reg(2'h3, 3'h2, 16'h0020);
        rd_reg(2'h3, 3'h3, 16'h0018, 16'hffff);
        wr_reg(2'h3, 3'h2, 16'h0000);
        rd_reg(2'h3, 3'h3, 16'h0010, 16'hffff);
        // Alternate pattern only, once selected
        wr_reg(2'h3, 3'h2, 16'h0200);
        rd_reg(2'h3, 3'h2, 16'h0200, 16'hffff);
        step(1'b0, 1'b1, 1'b0, 1);
        rd_reg(2'h3, 3'h3, 16'h0000, 16'h000c);
        step(1'b0, 1'b0, 1'b1, 1);
        rd_reg(2'h3, 3'h3, 16'h0008, 16'h000c);
        // Ports: random direction, drive and outside levels
        for (int i = 0; i < 6; i++) begin
            {dir, lv, ext_a, ext_b} = {$urandom, $urandom};
            ext = i[0] ? ext_b : ext_a;
            wr_reg(2'h3, 3'(4 + 2 * i[0]), dir);
            wr_reg(2'h3, 3'(5 + 2 * i[0]), lv);
            repeat (6) @(negedge clk_sys_i);
            rd_reg(2'h3, 3'(4 + 2 * i[0]), dir, 16'hffff);
            rd_reg(2'h3, 3'(5 + 2 * i[0]), (lv & dir) | (ext & ~dir), 16'hffff);
        end
        // Mailbox round trip through the codec model
        for (int i = 0; i < 3; i++) begin
            lv = 16'($urandom);
            wr_reg(2'h2, 3'h0, lv);
            rd_reg(2'h2, 3'h0, {8'h00, lv[7:0] ^ 8'h5a}, 16'hffff);
        end
        rd_reg(2'h1, 3'h5, 16'h0000, 16'hffff);
        rd_reg(2'h2, 3'h7, 16'h0000, 16'hffff);
        repeat (3) @(negedge clk_sys_i);
        stop_test();
    end
endmodule // tsg_status_regs_bench
bind tsg_status_regs tsg_regs_monitor u_mon (.*);
`default_nettype wire
